// *** src/ext_release_pkg.sv ***
// shared types and constants for the external bus release controller
package ext_release_pkg;

	// module-stop patterns that qualify a sleep for all-clocks-stopped mode
	localparam logic [15:0] MSTP_ALL_STOPPED = 16'hffff;
	localparam logic [15:0] MSTP_TIMER8_ONLY = 16'hfffe;
	localparam logic [15:0] EXMSTP_ALL_STOPPED = 16'hffff;

	// reset levels of the outputs
	localparam logic GRANT_N_RESET = 1'h1;
	localparam logic CANCEL_N_RESET = 1'h1;
	localparam logic ALL_BANKS_RESET = 1'h1;

	// arbitration takes one cycle after a low request is sampled
	localparam int unsigned ARB_CYCLES = 1;

	typedef enum logic [2:0] {
		ST_OWNED = 3'b000,
		ST_ARB = 3'b001,
		ST_RELEASED = 3'b010,
		ST_RECOVER = 3'b011,
		ST_STANDBY = 3'b100,
		ST_ALLSTOP = 3'b101
	} rel_state_t;

	typedef enum logic [1:0] {
		SLP_NONE = 2'b00,
		SLP_STANDBY = 2'b01,
		SLP_ALLSTOP = 2'b10
	} sleep_kind_t;

	typedef struct packed {
		logic ext_release_enable;
		logic release_cancel_output_enable;
		logic all_clocks_stop_enable;
		logic wait_insert_enable;
		logic [15:0] module_stop_control;
		logic [15:0] extended_module_stop_control;
	} cfg_t;

	typedef struct packed {
		logic ext_access_req;
		logic ext_cycle_busy;
		logic refresh_req;
		logic sleep_exec;
		logic sleep_standby;
		logic wake;
		logic sdram_space;
		logic ext_wait_n;
	} core_req_t;

endpackage

// *** src/external_bus_release_ctrl.sv ***
// external bus release arbitration with power-mode and refresh interplay
//
// Overview of operation
// - reset aborts any bus cycle at once and enters the reset state.
// - sleep with all-clocks-stop enabled and qualifying module-stop values stops all clocks.
// - no bus release serviced while all module clocks are stopped.
// - all-clocks-stopped entry during release waits until the bus returns.
// - internal masters keep working during release; only external accesses stall.
// - software standby entry during release waits until the bus returns.
// - release request during standby stays unanswered until standby is left.
// - no refresh cycles while released; pending refresh waits for recovery.
// - with cancel output enabled, refresh during release asserts the cancel request.
// - cancel output may go low together with grant, at the edge that ends arbitration.
// - external wait input ignored inside continuous synchronous DRAM space.
// - no DRAM bank management; every access selects all banks.
// - release granted only once the current external cycle has completed.
// - request going high deasserts the grant and ends the released state.
// - an already pending refresh wins over a bus release request.
// - cancel output low on external access, refresh or standby-type sleep during release.
`timescale 1ns/1ns

module external_bus_release_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire ext_release_pkg::cfg_t cfg,
	input wire ext_release_pkg::core_req_t core,
	input wire logic ext_release_request_in_n,
	output logic ext_release_grant_n_q,
	output logic release_cancel_request_out_n_q,
	output logic bus_released_q,
	output logic int_ext_grant_q,
	output logic int_access_ok_q,
	output logic refresh_start_q,
	output logic standby_enter_q,
	output logic all_stop_enter_q,
	output logic wait_insert_q,
	output logic all_banks_select_q
);

	ext_release_pkg::rel_state_t state_q;
	ext_release_pkg::rel_state_t state_d;
	ext_release_pkg::sleep_kind_t sleep_pend_q;
	logic refresh_pend_q;
	logic rel_req;
	logic allstop_ok;
	logic sleep_to_pend;
	logic refresh_now;
	logic int_grant_d;
	logic cancel_d;

	assign rel_req = cfg.ext_release_enable && !ext_release_request_in_n;

	assign allstop_ok = cfg.all_clocks_stop_enable
		&& cfg.extended_module_stop_control == ext_release_pkg::EXMSTP_ALL_STOPPED
		&& (cfg.module_stop_control == ext_release_pkg::MSTP_ALL_STOPPED
		|| cfg.module_stop_control == ext_release_pkg::MSTP_TIMER8_ONLY);

	assign sleep_to_pend = core.sleep_exec && (core.sleep_standby || allstop_ok);

	// refresh only while the bus is ours and no cycle runs
	assign refresh_now = state_q == ext_release_pkg::ST_OWNED && refresh_pend_q
		&& !core.ext_cycle_busy;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ext_release_pkg::ST_OWNED: begin
				if (rel_req && !refresh_pend_q && !core.ext_cycle_busy) begin
					state_d = ext_release_pkg::ST_ARB;
				end else if (!refresh_pend_q && !core.ext_cycle_busy
					&& sleep_pend_q == ext_release_pkg::SLP_STANDBY) begin
					state_d = ext_release_pkg::ST_STANDBY;
				end else if (!refresh_pend_q && !core.ext_cycle_busy
					&& sleep_pend_q == ext_release_pkg::SLP_ALLSTOP) begin
					state_d = ext_release_pkg::ST_ALLSTOP;
				end
			end
			ext_release_pkg::ST_ARB: begin
				state_d = ext_release_pkg::ST_RELEASED;
			end
			ext_release_pkg::ST_RELEASED: begin
				if (ext_release_request_in_n) begin
					state_d = ext_release_pkg::ST_RECOVER;
				end
			end
			ext_release_pkg::ST_RECOVER: begin
				state_d = ext_release_pkg::ST_OWNED;
			end
			ext_release_pkg::ST_STANDBY, ext_release_pkg::ST_ALLSTOP: begin
				if (core.wake) begin
					state_d = ext_release_pkg::ST_OWNED;
				end
			end
			default: begin
				state_d = ext_release_pkg::ST_OWNED;
			end
		endcase
	end

	// state; asynchronous reset drops any cycle in flight
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ext_release_pkg::ST_OWNED;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// pending sleep kind, held until the mode is entered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_pend_q <= ext_release_pkg::SLP_NONE;
		end else if (clk_en) begin
			if (sleep_to_pend) begin
				sleep_pend_q <= core.sleep_standby ? ext_release_pkg::SLP_STANDBY
					: ext_release_pkg::SLP_ALLSTOP;
			end else if (state_d == ext_release_pkg::ST_STANDBY
				|| state_d == ext_release_pkg::ST_ALLSTOP) begin
				sleep_pend_q <= ext_release_pkg::SLP_NONE;
			end
		end
	end

	// pending refresh; a new request wins over the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refresh_pend_q <= 1'h0;
		end else if (clk_en) begin
			if (core.refresh_req) begin
				refresh_pend_q <= 1'h1;
			end else if (refresh_now) begin
				refresh_pend_q <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refresh_start_q <= 1'h0;
		end else if (clk_en) begin
			refresh_start_q <= refresh_now;
		end
	end

	// grant and released status follow the next state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_release_grant_n_q <= ext_release_pkg::GRANT_N_RESET;
			bus_released_q <= 1'h0;
		end else if (clk_en) begin
			ext_release_grant_n_q <= state_d != ext_release_pkg::ST_RELEASED;
			bus_released_q <= state_d == ext_release_pkg::ST_RELEASED;
		end
	end

	// cancel request: during release, and already during arbitration
	always_comb begin
		cancel_d = 1'h0;
		if (cfg.release_cancel_output_enable
			&& (state_q == ext_release_pkg::ST_ARB
			|| state_q == ext_release_pkg::ST_RELEASED)) begin
			cancel_d = core.ext_access_req || core.refresh_req || refresh_pend_q
				|| sleep_to_pend || sleep_pend_q != ext_release_pkg::SLP_NONE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			release_cancel_request_out_n_q <= ext_release_pkg::CANCEL_N_RESET;
		end else if (clk_en) begin
			release_cancel_request_out_n_q <= !(cancel_d && !ext_release_request_in_n);
		end
	end

	// internal external access: loses to release and refresh
	assign int_grant_d = state_q == ext_release_pkg::ST_OWNED && state_d == state_q
		&& core.ext_access_req && !rel_req && !refresh_pend_q
		&& sleep_pend_q == ext_release_pkg::SLP_NONE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_ext_grant_q <= 1'h0;
			int_access_ok_q <= 1'h0;
		end else if (clk_en) begin
			int_ext_grant_q <= int_grant_d;
			int_access_ok_q <= state_d != ext_release_pkg::ST_STANDBY
				&& state_d != ext_release_pkg::ST_ALLSTOP;
		end
	end

	// one-cycle mode entry strobes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			standby_enter_q <= 1'h0;
			all_stop_enter_q <= 1'h0;
		end else if (clk_en) begin
			standby_enter_q <= state_q == ext_release_pkg::ST_OWNED
				&& state_d == ext_release_pkg::ST_STANDBY;
			all_stop_enter_q <= state_q == ext_release_pkg::ST_OWNED
				&& state_d == ext_release_pkg::ST_ALLSTOP;
		end
	end

	// sdram: wait pin ignored, all banks always selected
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_insert_q <= 1'h0;
			all_banks_select_q <= ext_release_pkg::ALL_BANKS_RESET;
		end else if (clk_en) begin
			wait_insert_q <= cfg.wait_insert_enable && !core.ext_wait_n
				&& !core.sdram_space;
			all_banks_select_q <= ext_release_pkg::ALL_BANKS_RESET;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_grant_needs_idle: assert property (clk_en && core.ext_cycle_busy
		&& state_q == ext_release_pkg::ST_OWNED |=> ext_release_grant_n_q)
		else $error("grant given during an external cycle");
	a_refresh_first: assert property (clk_en && state_q == ext_release_pkg::ST_OWNED
		&& refresh_pend_q && rel_req && !core.ext_cycle_busy
		|=> refresh_start_q && state_q == ext_release_pkg::ST_OWNED)
		else $error("release granted ahead of refresh");
	a_no_refresh_rel: assert property (bus_released_q |-> !refresh_start_q)
		else $error("refresh while bus released");
	a_grant_release: assert property (clk_en && state_q == ext_release_pkg::ST_ARB
		##1 clk_en && ext_release_request_in_n |-> !ext_release_grant_n_q ##1 ext_release_grant_n_q)
		else $error("grant not withdrawn after request high");
	a_arb_to_grant: assert property (clk_en && rel_req && !refresh_pend_q
		&& !core.ext_cycle_busy && state_q == ext_release_pkg::ST_OWNED
		##1 clk_en |=> !ext_release_grant_n_q)
		else $error("grant not given two cycles after request");
	a_standby_deferred: assert property (bus_released_q |-> !standby_enter_q
		&& !all_stop_enter_q)
		else $error("power mode entered while released");
	a_standby_deaf: assert property (clk_en && state_q == ext_release_pkg::ST_STANDBY
		&& !core.wake |=> ext_release_grant_n_q && state_q == ext_release_pkg::ST_STANDBY)
		else $error("release answered in standby");
	a_allstop_deaf: assert property (state_q == ext_release_pkg::ST_ALLSTOP
		|-> ext_release_grant_n_q)
		else $error("release answered with clocks stopped");
	a_cancel_refresh: assert property (clk_en && cfg.release_cancel_output_enable
		&& state_q == ext_release_pkg::ST_RELEASED && refresh_pend_q
		&& !ext_release_request_in_n |=> !release_cancel_request_out_n_q)
		else $error("cancel request missing for refresh");
	a_no_ext_grant_rel: assert property (bus_released_q |-> !int_ext_grant_q)
		else $error("internal external access during release");
	a_wait_ignored: assert property (clk_en && core.sdram_space |=> !wait_insert_q)
		else $error("wait inserted in sdram space");
	a_banks_all: assert property (all_banks_select_q)
		else $error("bank select not all");

	c_release_cycle: cover property (state_q == ext_release_pkg::ST_RELEASED
		##[1:20] state_q == ext_release_pkg::ST_RECOVER);
	c_cancel_early: cover property (state_q == ext_release_pkg::ST_ARB
		##1 !release_cancel_request_out_n_q);
	c_standby_after: cover property (bus_released_q ##[1:20] standby_enter_q);
	c_allstop: cover property (all_stop_enter_q);

endmodule

// *** verification/ext_master_model.sv ***
// behavioural external bus master that borrows the bus
`timescale 1ns/1ns

module ext_master_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [7:0] hold,
	input wire logic grant_n,
	input wire logic cancel_n,
	output logic req_n
);
	logic g;
	int n;
	initial req_n = 1'h1;
	always begin
		@(posedge clk);
		g = go;
		#10;
		if (g && req_n) begin
			req_n = 1'h0;
			n = 0;
		end else if (!req_n) begin
			if (grant_n === 1'h0) n++;
			if (rst || n > hold || cancel_n === 1'h0) req_n = 1'h1;
		end
	end
endmodule

// *** verification/test_external_bus_release_ctrl.sv ***
// self-checking bench for the external bus release controller
`timescale 1ns/1ns

module test_external_bus_release_ctrl;
	typedef struct {logic [1:0] k; logic v; int c;} note_t;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic go = 1'h0;
	logic [7:0] hold = 8'h05;
	logic req_n, grant_n, cancel_n, released, ext_ok, int_ok, ref_s, stby_s, stop_s, wait_s, banks;
	logic prev_g = 1'h1;
	logic x, y;
	ext_release_pkg::cfg_t cfg = '0;
	ext_release_pkg::core_req_t core = '0;
	note_t q[$];
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 18350;

	always #50 clk = ~clk;

	external_bus_release_ctrl external_bus_release_ctrl_i (.clk(clk), .rst(rst), .clk_en(1'h1),
		.cfg(cfg), .core(core), .ext_release_request_in_n(req_n),
		.ext_release_grant_n_q(grant_n), .release_cancel_request_out_n_q(cancel_n),
		.bus_released_q(released), .int_ext_grant_q(ext_ok), .int_access_ok_q(int_ok),
		.refresh_start_q(ref_s), .standby_enter_q(stby_s), .all_stop_enter_q(stop_s),
		.wait_insert_q(wait_s), .all_banks_select_q(banks));

	ext_master_model ext_master_model_i (.clk(clk), .rst(rst), .go(go), .hold(hold),
		.grant_n(grant_n), .cancel_n(cancel_n), .req_n(req_n));

	task automatic chk_ev(input logic [1:0] k, input logic v);
		note_t w;
		n_checks++;
		if (q.size() == 0) w = '{2'h3, 1'hx, 0};
		else w = q.pop_front();
		if (w.k !== k || w.v !== v || (w.c != 0 && w.c != cyc)) begin
			fail_count++;
			$display("[ERR] %0t exp %h/%h@%h got %h/%h@%h", $time, w.k, w.v, w.c, k, v, cyc);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask

	// start the partner; d is the expected grant delay, 0 loose, negative none
	task automatic borrow(input logic [7:0] h, input int d);
		step(1);
		hold = h;
		go = 1'h1;
		if (d >= 0) q.push_back('{2'h0, 1'h0, d ? cyc + d : 0});
		step(1);
		go = 1'h0;
	endtask

	task automatic drain;
		int n;
		n = 0;
		while (q.size() != 0 && n < 200) begin
			step(1);
			n++;
		end
		chk_bit(q.size() == 0, 1'h1);
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			fail_count++;
			end_of_test;
		end
	end

	// event watcher: grant edges and mode pulses
	always @(posedge clk) begin
		#1;
		if (grant_n !== prev_g) chk_ev(2'h0, grant_n);
		prev_g = grant_n;
		if (ref_s === 1'h1) chk_ev(2'h1, 1'h1);
		if (stby_s === 1'h1) chk_ev(2'h2, 1'h1);
		if (stop_s === 1'h1) chk_ev(2'h3, 1'h1);
	end

	initial begin
		core.ext_wait_n = 1'h1;
		step(20);
		rst = 1'h0;
		chk_bit(grant_n, 1'h1);
		chk_bit(cancel_n, 1'h1);
		chk_bit(banks, 1'h1);
		cfg.ext_release_enable = 1'h1;
		// refresh latched one edge ahead, so it meets the request at the same edge
		q.push_back('{2'h1, 1'h1, 0});
		q.push_back('{2'h0, 1'h0, 0});
		core.ext_access_req = 1'h1;
		hold = 8'h08;
		step(1);
		go = 1'h1;
		core.refresh_req = 1'h1;
		step(1);
		go = 1'h0;
		core.refresh_req = 1'h0;
		drain;
		step(2);
		chk_bit(int_ok, 1'h1);
		chk_bit(ext_ok, 1'h0);
		core.ext_access_req = 1'h0;
		q.push_back('{2'h0, 1'h1, 0});
		drain;
		core.ext_cycle_busy = 1'h1;
		borrow(8'h00, -1);
		step(6);
		chk_bit(grant_n, 1'h1);
		q.push_back('{2'h0, 1'h0, cyc + 2});
		q.push_back('{2'h0, 1'h1, 0});
		core.ext_cycle_busy = 1'h0;
		drain;
		cfg.release_cancel_output_enable = 1'h1;
		borrow(8'h60, 3);
		drain;
		q.push_back('{2'h0, 1'h1, 0});
		q.push_back('{2'h1, 1'h1, 0});
		core.refresh_req = 1'h1;
		step(1);
		core.refresh_req = 1'h0;
		chk_bit(cancel_n, 1'h0);
		drain;
		cfg.all_clocks_stop_enable = 1'h1;
		cfg.extended_module_stop_control = 16'hffff;
		for (int k = 0; k < 2; k++) begin
			x = 1'($random(seed));
			cfg.module_stop_control = x ? 16'hffff : 16'hfffe;
			borrow(8'h60, 3);
			drain;
			q.push_back('{2'h0, 1'h1, 0});
			q.push_back('{2'h2 + 2'(k), 1'h1, 0});
			core.sleep_standby = (k == 0);
			core.sleep_exec = 1'h1;
			step(1);
			core.sleep_exec = 1'h0;
			chk_bit(cancel_n, 1'h0);
			drain;
			borrow(8'h04, -1);
			step(8);
			chk_bit(grant_n, 1'h1);
			q.push_back('{2'h0, 1'h0, 0});
			q.push_back('{2'h0, 1'h1, 0});
			core.wake = 1'h1;
			step(1);
			core.wake = 1'h0;
			drain;
		end
		for (int i = 0; i < 24; i++) begin
			{cfg.wait_insert_enable, core.ext_wait_n, core.sdram_space} = 3'($random(seed));
			y = cfg.wait_insert_enable & !core.ext_wait_n & !core.sdram_space;
			step(1);
			chk_bit(wait_s, y);
		end
		borrow(8'h60, 3);
		drain;
		q.push_back('{2'h0, 1'h1, 0});
		step(1);
		rst = 1'h1;
		#1 chk_bit(grant_n, 1'h1);
		chk_bit(released, 1'h0);
		step(2);
		rst = 1'h0;
		step(2);
		drain;
		end_of_test;
	end
endmodule
